// ===== logic/rtsr_map.svh
// register offsets, reset values and field positions of the radio test and status bank
`ifndef RTSR_MAP_SVH
`define RTSR_MAP_SVH
`define RTSR_OFS_PRODUCTION_TRIM   6'h2A
`define RTSR_OFS_GAIN_CONTROL_TRIM 6'h2B
`define RTSR_OFS_ANALOG_TRIM_B     6'h2C
`define RTSR_OFS_ANALOG_TRIM_A     6'h2D
`define RTSR_OFS_CALIBRATION_TRIM  6'h2E
`define RTSR_OFS_CHIP_PART_ID      6'h30
`define RTSR_OFS_CHIP_REVISION_ID  6'h31
`define RTSR_OFS_FREQ_OFFSET_EST   6'h32
`define RTSR_OFS_LINK_QUALITY      6'h33
`define RTSR_OFS_SIGNAL_STRENGTH   6'h34
`define RTSR_OFS_RADIO_FSM_STATE   6'h35
`define RTSR_RST_PRODUCTION_TRIM   8'h7F
`define RTSR_RST_GAIN_CONTROL_TRIM 8'h3F
`define RTSR_RST_ANALOG_TRIM_B     8'h88
`define RTSR_RST_ANALOG_TRIM_A     8'h31
`define RTSR_RST_CALIBRATION_TRIM  8'h0B
`define RTSR_WAKE_TRIM_B_RETAIN0   8'h88
`define RTSR_WAKE_TRIM_B_RETAIN1   8'h81
`define RTSR_WAKE_TRIM_A_RETAIN0   8'h31
`define RTSR_WAKE_TRIM_A_RETAIN1   8'h35
`define RTSR_BIT_OSC_SEL_CAL_EN    1
`define RTSR_BIT_CRC_MATCH         7
`define RTSR_LQI_SYMBOLS           7'h40
`define RTSR_STATE_CODE_MAX        5'h16
`endif

// ===== logic/rtsr_pkg.sv
// types shared by the radio test and status bank
package rtsr_pkg;
   typedef enum logic [4:0] {
      ST_SLEEP = 5'b00000, ST_IDLE = 5'b00001, ST_CRYSTAL_OFF = 5'b00010,
      ST_VCOON_MC = 5'b00011, ST_REGON_MC = 5'b00100, ST_MANUAL_CAL = 5'b00101,
      ST_VCOON = 5'b00110, ST_REGON = 5'b00111, ST_STARTCAL = 5'b01000,
      ST_BWBOOST = 5'b01001, ST_FS_LOCK = 5'b01010, ST_IFADCON = 5'b01011,
      ST_ENDCAL = 5'b01100, ST_RX = 5'b01101, ST_RX_END = 5'b01110,
      ST_RX_RST = 5'b01111, ST_TXRX_SWITCH = 5'b10000,
      ST_RX_QUEUE_OVERRUN = 5'b10001, ST_SYNTH_ON_TX_READY = 5'b10010,
      ST_TX = 5'b10011, ST_TX_END = 5'b10100, ST_RXTX_SWITCH = 5'b10101,
      ST_TX_QUEUE_UNDERRUN = 5'b10110
   } rtsr_state_e;

   // register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rtsr_req_s;

   // datapath observations of the radio
   typedef struct packed {
      logic        sleep_wake;
      logic        retain_sel;
      logic        fsk_mod;
      logic        rx_enter;
      logic        crc_done;
      logic        crc_match;
      logic        sync_found;
      logic        symbol_strobe;
      logic [7:0]  symbol_quality;
      logic [7:0]  offset_sample;
      logic        offset_valid;
      logic [7:0]  signal_strength;
   } rtsr_radio_s;
endpackage : rtsr_pkg

// ===== logic/rtsr_lqi_acc.sv
// link-quality averaging over the symbols after a sync word
`timescale 1ns/10ps
`default_nettype none
`include "rtsr_map.svh"
module rtsr_lqi_acc (
   input  wire logic       i_clk_sys,
   input  wire logic       i_srst,
   input  wire logic       i_ce,
   input  wire logic       i_sync_found,
   input  wire logic       i_symbol_strobe,
   input  wire logic [7:0] i_symbol_quality,
   output logic      [6:0] o_lqi
);
   logic [6:0]  cnt_ff;
   logic [14:0] sum_ff;
   logic        busy_ff;
   logic [6:0]  lqi_ff;
   logic [14:0] nxt_sum;

   assign nxt_sum = sum_ff + {7'h00, i_symbol_quality};
   assign o_lqi   = lqi_ff;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         cnt_ff  <= 7'h00;
         sum_ff  <= 15'h0000;
         busy_ff <= 1'b0;
         lqi_ff  <= 7'h00;
      end else if (i_ce) begin
         if (i_sync_found) begin
            cnt_ff  <= 7'h00;
            sum_ff  <= 15'h0000;
            busy_ff <= 1'b1;
         end else if (busy_ff && i_symbol_strobe) begin
            if (cnt_ff == `RTSR_LQI_SYMBOLS - 7'h01) begin
               busy_ff <= 1'b0;
               // sum of 64 eight-bit samples over 256, the average divided by four
               lqi_ff  <= nxt_sum[14:8];
            end else begin
               cnt_ff <= cnt_ff + 7'h01;
               sum_ff <= nxt_sum;
            end
         end
      end
   end

   AST_LQI_COUNT_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      cnt_ff < `RTSR_LQI_SYMBOLS) else $error("lqi symbol count overran");
endmodule : rtsr_lqi_acc
`default_nettype wire

// ===== logic/rtsr_state_track.sv
// main control state code holder with legal-code guard
`timescale 1ns/10ps
`default_nettype none
`include "rtsr_map.svh"
module rtsr_state_track (
   input  wire logic       i_clk_sys,
   input  wire logic       i_srst,
   input  wire logic       i_ce,
   input  wire logic [4:0] i_state_code,
   output logic      [4:0] o_state_code
);
   rtsr_pkg::rtsr_state_e state_ff;
   rtsr_pkg::rtsr_state_e nxt_state;

   always_comb begin
      case (i_state_code)
         5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F: nxt_state = state_ff;
         default: nxt_state = rtsr_pkg::rtsr_state_e'(i_state_code);
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_ff <= rtsr_pkg::ST_IDLE;
      end else if (i_ce) begin
         state_ff <= nxt_state;
      end
   end

   assign o_state_code = state_ff;

   AST_STATE_RANGE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      state_ff <= `RTSR_STATE_CODE_MAX) else $error("state code out of range");
endmodule : rtsr_state_track
`default_nettype wire

// ===== logic/rtsr_regs.sv
// radio test settings and status register bank
`timescale 1ns/10ps
`default_nettype none
`include "rtsr_map.svh"
module rtsr_regs #(
   parameter logic [7:0] PART_ID     = 8'hA5, // arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h5A  // arbitrary value
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_srst,
   input  wire logic                  i_ce,
   input  wire rtsr_pkg::rtsr_req_s   i_req,
   output logic                 [7:0] o_rdata,
   input  wire rtsr_pkg::rtsr_radio_s i_radio,
   input  wire logic            [4:0] i_state_code,
   output logic                       o_osc_select_cal_enable,
   output logic                 [7:0] o_production_trim,
   output logic                 [7:0] o_gain_control_trim,
   output logic                 [7:0] o_analog_trim_a,
   output logic                 [7:0] o_analog_trim_b,
   output logic                 [7:0] o_calibration_trim
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] production_trim_ff;
   logic [7:0] gain_control_trim_ff;
   logic [7:0] analog_trim_b_ff;
   logic [7:0] analog_trim_a_ff;
   logic [7:0] calibration_trim_ff;
   logic [7:0] carrier_offset_value_ff;
   logic       crc_match_ff;
   logic [7:0] signal_strength_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [6:0] link_quality_value;
   logic [4:0] main_control_state_code;
   logic       wr_hit;

   assign wr_hit = i_req.wr && !i_req.rd;

   ////////////////////////////////////////////////////////////////////////////////
   // writable trim registers
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         production_trim_ff   <= `RTSR_RST_PRODUCTION_TRIM;
         gain_control_trim_ff <= `RTSR_RST_GAIN_CONTROL_TRIM;
         calibration_trim_ff  <= `RTSR_RST_CALIBRATION_TRIM;
      end else if (i_ce && wr_hit) begin
         case (i_req.addr)
            `RTSR_OFS_PRODUCTION_TRIM:   production_trim_ff   <= i_req.wdata;
            `RTSR_OFS_GAIN_CONTROL_TRIM: gain_control_trim_ff <= i_req.wdata;
            `RTSR_OFS_CALIBRATION_TRIM:  calibration_trim_ff  <= i_req.wdata;
            default: begin
            end
         endcase
      end
   end

   // analog trims: wake reload beats a same-cycle host write
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         analog_trim_b_ff <= `RTSR_RST_ANALOG_TRIM_B;
         analog_trim_a_ff <= `RTSR_RST_ANALOG_TRIM_A;
      end else if (i_ce) begin
         if (i_radio.sleep_wake) begin
            analog_trim_b_ff <= i_radio.retain_sel ? `RTSR_WAKE_TRIM_B_RETAIN1
                                                   : `RTSR_WAKE_TRIM_B_RETAIN0;
            analog_trim_a_ff <= i_radio.retain_sel ? `RTSR_WAKE_TRIM_A_RETAIN1
                                                   : `RTSR_WAKE_TRIM_A_RETAIN0;
         end else if (wr_hit && i_req.addr == `RTSR_OFS_ANALOG_TRIM_B) begin
            analog_trim_b_ff <= i_req.wdata;
         end else if (wr_hit && i_req.addr == `RTSR_OFS_ANALOG_TRIM_A) begin
            analog_trim_a_ff <= i_req.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status capture
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         carrier_offset_value_ff <= 8'h00;
      end else if (i_ce) begin
         if (!i_radio.fsk_mod) begin
            carrier_offset_value_ff <= 8'h00;
         end else if (i_radio.offset_valid) begin
            carrier_offset_value_ff <= i_radio.offset_sample;
         end
      end
   end

   // a match report in the entry cycle wins over the clear
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         crc_match_ff <= 1'b0;
      end else if (i_ce) begin
         if (i_radio.crc_done) begin
            crc_match_ff <= i_radio.crc_match;
         end else if (i_radio.rx_enter) begin
            crc_match_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         signal_strength_ff <= 8'h00;
      end else if (i_ce) begin
         signal_strength_ff <= i_radio.signal_strength;
      end
   end

   rtsr_lqi_acc u_lqi (
      .i_clk_sys        (i_clk_sys),
      .i_srst           (i_srst),
      .i_ce             (i_ce),
      .i_sync_found     (i_radio.sync_found),
      .i_symbol_strobe  (i_radio.symbol_strobe),
      .i_symbol_quality (i_radio.symbol_quality),
      .o_lqi            (link_quality_value)
   );

   rtsr_state_track u_state (
      .i_clk_sys    (i_clk_sys),
      .i_srst       (i_srst),
      .i_ce         (i_ce),
      .i_state_code (i_state_code),
      .o_state_code (main_control_state_code)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe, zero after any other enabled cycle
   always_comb begin
      case (i_req.addr)
         `RTSR_OFS_PRODUCTION_TRIM:   nxt_rdata = production_trim_ff;
         `RTSR_OFS_GAIN_CONTROL_TRIM: nxt_rdata = gain_control_trim_ff;
         `RTSR_OFS_ANALOG_TRIM_B:     nxt_rdata = analog_trim_b_ff;
         `RTSR_OFS_ANALOG_TRIM_A:     nxt_rdata = analog_trim_a_ff;
         `RTSR_OFS_CALIBRATION_TRIM:  nxt_rdata = calibration_trim_ff;
         `RTSR_OFS_CHIP_PART_ID:      nxt_rdata = PART_ID;
         `RTSR_OFS_CHIP_REVISION_ID:  nxt_rdata = REVISION_ID;
         `RTSR_OFS_FREQ_OFFSET_EST:   nxt_rdata = carrier_offset_value_ff;
         `RTSR_OFS_LINK_QUALITY:      nxt_rdata = {crc_match_ff, link_quality_value};
         `RTSR_OFS_SIGNAL_STRENGTH:   nxt_rdata = signal_strength_ff;
         `RTSR_OFS_RADIO_FSM_STATE:   nxt_rdata = {3'h0, main_control_state_code};
         default:                     nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rdata_ff <= 8'h00;
      end else if (i_ce) begin
         rdata_ff <= i_req.rd ? nxt_rdata : 8'h00;
      end
   end

   assign o_rdata                 = rdata_ff;
   assign o_osc_select_cal_enable = calibration_trim_ff[`RTSR_BIT_OSC_SEL_CAL_EN];
   assign o_production_trim       = production_trim_ff;
   assign o_gain_control_trim     = gain_control_trim_ff;
   assign o_analog_trim_a         = analog_trim_a_ff;
   assign o_analog_trim_b         = analog_trim_b_ff;
   assign o_calibration_trim      = calibration_trim_ff;

   ////////////////////////////////////////////////////////////////////////////////
   sequence wake_s;
      i_ce && i_radio.sleep_wake;
   endsequence

   sequence host_wr_s;
      i_ce && i_req.wr && !i_req.rd;
   endsequence

   sequence host_rd_s;
      i_ce && i_req.rd;
   endsequence

   sequence frozen_s;
      !i_ce;
   endsequence

   sequence rx_clear_s;
      i_ce && i_radio.rx_enter && !i_radio.crc_done;
   endsequence

   sequence crc_load_s;
      i_ce && i_radio.crc_done;
   endsequence

   AST_WAKE_TRIM_B: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      wake_s |=> analog_trim_b_ff == ($past(i_radio.retain_sel) ? 8'h81 : 8'h88))
      else $error("trim B not reloaded on wake");
   AST_WAKE_TRIM_A: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      wake_s |=> analog_trim_a_ff == ($past(i_radio.retain_sel) ? 8'h35 : 8'h31))
      else $error("trim A not reloaded on wake");
   AST_CAL_ENABLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 i_req.addr == 6'h2E |=> o_osc_select_cal_enable == $past(i_req.wdata[1]))
      else $error("cal enable mismatch");
   AST_OFFSET_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_radio.fsk_mod && i_radio.offset_valid
      |=> carrier_offset_value_ff == $past(i_radio.offset_sample))
      else $error("offset not captured");
   AST_OFFSET_ZERO_ASK: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && !i_radio.fsk_mod |=> carrier_offset_value_ff == 8'h00)
      else $error("offset nonzero under amplitude keying");
   AST_CRC_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_radio.rx_enter && !i_radio.crc_done |=> !crc_match_ff)
      else $error("crc match not cleared on rx entry");
   AST_SIGNAL_STRENGTH_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_req.rd && i_req.addr == 6'h34 |=> o_rdata == $past(signal_strength_ff))
      else $error("signal_strength read mismatch");
   AST_STATE_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_req.rd && i_req.addr == 6'h35 |=> o_rdata[7:5] == 3'h0)
      else $error("state upper bits nonzero");

   ////////////////////////////////////////////////////////////////////////////////
   // status behaviour
   AST_CRC_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      crc_load_s |=> crc_match_ff == $past(i_radio.crc_match))
      else $error("crc match not loaded");
   AST_CRC_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && !i_radio.crc_done && !i_radio.rx_enter |=> $stable(crc_match_ff))
      else $error("crc match changed without event");
   AST_CRC_CLEAR_SEQ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      rx_clear_s |=> crc_match_ff == 1'b0)
      else $error("crc match survived rx entry");
   AST_OFFSET_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_radio.fsk_mod && !i_radio.offset_valid |=> $stable(carrier_offset_value_ff))
      else $error("offset changed without sample");
   AST_SIGNAL_STRENGTH_TRACK: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce |=> signal_strength_ff == $past(i_radio.signal_strength))
      else $error("signal strength not tracked");

   ////////////////////////////////////////////////////////////////////////////////
   // clock enable freezes everything
   AST_CE_FREEZE_TRIM: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      frozen_s |=> $stable(analog_trim_a_ff) && $stable(analog_trim_b_ff)
                   && $stable(calibration_trim_ff) && $stable(production_trim_ff))
      else $error("trim changed while frozen");
   AST_CE_FREEZE_STATUS: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      frozen_s |=> $stable(carrier_offset_value_ff) && $stable(crc_match_ff)
                   && $stable(signal_strength_ff))
      else $error("status changed while frozen");
   AST_CE_FREEZE_RDATA: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      frozen_s |=> $stable(o_rdata))
      else $error("read data changed while frozen");

   ////////////////////////////////////////////////////////////////////////////////
   // host writes
   AST_WR_TRIM_B: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 (i_req.addr == 6'h2C && !i_radio.sleep_wake)
      |=> analog_trim_b_ff == $past(i_req.wdata))
      else $error("trim B write lost");
   AST_WR_TRIM_A: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 (i_req.addr == 6'h2D && !i_radio.sleep_wake)
      |=> analog_trim_a_ff == $past(i_req.wdata))
      else $error("trim A write lost");
   AST_WR_CAL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 i_req.addr == 6'h2E |=> calibration_trim_ff == $past(i_req.wdata))
      else $error("calibration trim write lost");
   AST_WR_GAIN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 i_req.addr == 6'h2B |=> gain_control_trim_ff == $past(i_req.wdata))
      else $error("gain trim write lost");
   AST_WR_PROD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_wr_s ##0 i_req.addr == 6'h2A |=> production_trim_ff == $past(i_req.wdata))
      else $error("production trim write lost");
   AST_WR_RD_CLASH: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_req.wr && i_req.rd
      |=> $stable(calibration_trim_ff) && $stable(production_trim_ff)
          && $stable(gain_control_trim_ff))
      else $error("write taken beside a read");

   ////////////////////////////////////////////////////////////////////////////////
   // host reads
   AST_RDATA_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && !i_req.rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_PART_ID_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h30 |=> o_rdata == PART_ID)
      else $error("part id read mismatch");
   AST_REV_ID_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h31 |=> o_rdata == REVISION_ID)
      else $error("revision id read mismatch");
   AST_OFFSET_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h32 |=> o_rdata == $past(carrier_offset_value_ff))
      else $error("offset read mismatch");
   AST_LQI_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h33
      |=> o_rdata == $past({crc_match_ff, link_quality_value}))
      else $error("link quality read mismatch");
   AST_STATE_VALUE_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h35 |=> o_rdata[4:0] == $past(main_control_state_code))
      else $error("state code read mismatch");
   AST_TRIM_B_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h2C |=> o_rdata == $past(analog_trim_b_ff))
      else $error("trim B read mismatch");
   AST_TRIM_A_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h2D |=> o_rdata == $past(analog_trim_a_ff))
      else $error("trim A read mismatch");
   AST_CAL_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 i_req.addr == 6'h2E |=> o_rdata == $past(calibration_trim_ff))
      else $error("calibration trim read mismatch");
   AST_UNMAPPED_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      host_rd_s ##0 (i_req.addr == 6'h2F || i_req.addr < 6'h2A || i_req.addr > 6'h35)
      |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : rtsr_regs
`default_nettype wire

// ===== dv/rtsr_radio_model.sv
// radio datapath model: one sync word, then 64 symbols with a quality each
`timescale 1ns/10ps
`default_nettype none
module rtsr_radio_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_go,
   input  wire logic [7:0] i_quality,
   output logic            o_sync_found,
   output logic            o_symbol_strobe,
   output logic      [7:0] o_symbol_quality,
   output logic            o_busy
);
   logic [7:0] cnt_ff = 8'h00;
   logic       gap_ff = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // symbols come every other cycle, the way a slow demodulator hands them over
   always_ff @(posedge i_clk_sys) begin
      o_sync_found <= i_go;
      o_symbol_strobe <= 1'b0;
      gap_ff <= ~gap_ff;
      if (i_go) begin
         cnt_ff <= 8'h40;
      end else if (cnt_ff != 8'h00 && gap_ff) begin
         o_symbol_strobe <= 1'b1;
         cnt_ff <= cnt_ff - 8'h01;
      end
   end

   // quality is only meaningful beside a strobe, otherwise it shows the inverse
   assign o_symbol_quality = o_symbol_strobe ? i_quality : ~i_quality;
   assign o_busy = (cnt_ff != 8'h00) || i_go || o_sync_found;
endmodule : rtsr_radio_model
`default_nettype wire

// ===== dv/radio_test_status_regs_tb_top.sv
// self-checking bench for the radio test and status register bank
`timescale 1ns/10ps
`default_nettype none
module radio_test_status_regs_tb_top;
   logic                  clk_sys    = 1'b0;
   logic                  srst       = 1'b1;
   logic                  ce         = 1'b1;
   logic            [7:0] trim_prod;
   logic            [7:0] trim_gain;
   logic                  go         = 1'b0;
   logic            [7:0] quality    = 8'h80;
   logic            [4:0] state_code = 5'h01;
   rtsr_pkg::rtsr_req_s   req        = '0;
   rtsr_pkg::rtsr_radio_s rad        = '0;
   rtsr_pkg::rtsr_radio_s rad_in;
   logic            [7:0] rdata;
   logic            [7:0] trim_b;
   logic            [7:0] trim_a;
   logic            [7:0] trim_cal;
   logic                  cal_en;
   logic                  p_sync;
   logic                  p_strobe;
   logic            [7:0] p_quality;
   logic                  busy;
   int                    err_total  = 0;
   int                    checks     = 0;
   logic            [7:0] rst_tab [5] = '{8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B};

   always #2 clk_sys = ~clk_sys;

   always_comb begin
      rad_in = rad;
      rad_in.sync_found = p_sync;
      rad_in.symbol_strobe = p_strobe;
      rad_in.symbol_quality = p_quality;
   end

   rtsr_regs dut_u (.i_clk_sys(clk_sys), .i_srst(srst), .i_ce(ce), .i_req(req),
      .o_rdata(rdata), .i_radio(rad_in), .i_state_code(state_code),
      .o_osc_select_cal_enable(cal_en), .o_production_trim(trim_prod),
      .o_gain_control_trim(trim_gain),
      .o_analog_trim_a(trim_a), .o_analog_trim_b(trim_b), .o_calibration_trim(trim_cal));

   rtsr_radio_model radio_u (.i_clk_sys(clk_sys), .i_go(go), .i_quality(quality),
      .o_sync_found(p_sync), .o_symbol_strobe(p_strobe), .o_symbol_quality(p_quality),
      .o_busy(busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so they are sampled there
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd

   task automatic wake(input logic ret);
      @(posedge clk_sys);
      rad.retain_sel <= ret;
      rad.sleep_wake <= 1'b1;
      @(posedge clk_sys);
      rad.sleep_wake <= 1'b0;
      tick(2);
   endtask : wake

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(12);
      srst <= 1'b0;
      #1;
      chk({7'h00, cal_en}, 8'h01);
      chk(trim_prod, 8'h7F);
      chk(trim_gain, 8'h3F);
      for (int k = 0; k < 5; k++) begin
         rd(6'h2A + 6'(k), rst_tab[k]);
      end
      rd(6'h30, 8'hA5);
      rd(6'h31, 8'h5A);
      rd(6'h35, 8'h01);
      rd(6'h2F, 8'h00);
      wr(6'h30, 8'h00);
      rd(6'h30, 8'hA5);
      wr(6'h34, 8'h77);
      rd(6'h34, 8'h00);
      wr(6'h2E, 8'h00);
      #1;
      chk({7'h00, cal_en}, 8'h00);
      rd(6'h2E, 8'h00);
      wr(6'h2E, 8'h02);
      #1;
      chk({7'h00, cal_en}, 8'h01);
      ce <= 1'b0;
      wr(6'h2E, 8'h00);
      #1;
      chk({7'h00, cal_en}, 8'h01);
      ce <= 1'b1;
      rd(6'h2E, 8'h02);
      wr(6'h2A, 8'hBF);
      #1;
      chk(trim_prod, 8'hBF);
      rd(6'h2A, 8'hBF);
      wr(6'h2C, 8'h12);
      wr(6'h2D, 8'h34);
      wake(1'b1);
      chk(trim_b, 8'h81);
      chk(trim_a, 8'h35);
      rd(6'h2D, 8'h35);
      wr(6'h2C, 8'h56);
      wake(1'b0);
      rd(6'h2C, 8'h88);
      rd(6'h2D, 8'h31);
      rad.fsk_mod <= 1'b1;
      rad.offset_sample <= 8'hF0;
      rad.offset_valid <= 1'b1;
      tick(1);
      rad.offset_valid <= 1'b0;
      rad.offset_sample <= 8'h0F;
      tick(2);
      rd(6'h32, 8'hF0);
      rad.fsk_mod <= 1'b0;
      tick(2);
      rd(6'h32, 8'h00);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
         tick(1);
      end
      if (busy !== 1'b0) begin
         err_total++;
         $display("ERROR t=%0t symbol burst never ended", $time);
         tally_and_finish();
      end
      tick(2);
      rd(6'h33, {1'b0, 7'((16'h0040 * quality) >> 8)});
      rad.crc_match <= 1'b1;
      rad.crc_done <= 1'b1;
      tick(1);
      rad.crc_done <= 1'b0;
      tick(2);
      rd(6'h33, {1'b1, 7'((16'h0040 * quality) >> 8)});
      rad.rx_enter <= 1'b1;
      tick(1);
      rad.rx_enter <= 1'b0;
      tick(2);
      rd(6'h33, {1'b0, 7'((16'h0040 * quality) >> 8)});
      rad.signal_strength <= 8'hC3;
      tick(3);
      rd(6'h34, 8'hC3);
      state_code <= 5'h16;
      tick(3);
      rd(6'h35, 8'h16);
      state_code <= 5'h19;
      tick(3);
      rd(6'h35, 8'h16);
      tally_and_finish();
   end

   initial begin
      #200000;
      err_total++;
      $display("ERROR t=%0t run took too long", $time);
      tally_and_finish();
   end
endmodule : radio_test_status_regs_tb_top
`default_nettype wire
